// ===== logic/fsps_defs.svh
`ifndef FSPS_DEFS_SVH
`define FSPS_DEFS_SVH

// register offsets on the plain software port
`define FSPS_ADDR_CMD        4'h0
`define FSPS_ADDR_BLK_PTR    4'h1
`define FSPS_ADDR_OFS_PTR    4'h2
`define FSPS_ADDR_BLK_CMP    4'h3
`define FSPS_ADDR_OFS_CMP    4'h4
`define FSPS_ADDR_WBUF       4'h5
`define FSPS_ADDR_STATUS     4'h6
`define FSPS_ADDR_UNLOCK     4'h7
`define FSPS_ADDR_MODE       4'h8
`define FSPS_ADDR_PROT       4'h9
`define FSPS_ADDR_IRQ_STAT   4'ha
`define FSPS_ADDR_IRQ_MASK   4'hb

// command codes
`define FSPS_CMD_NONE        8'h00
`define FSPS_CMD_ERASE       8'h03
`define FSPS_CMD_BLANK       8'h04
`define FSPS_CMD_WRITE       8'h05

// unlock and mode sequence values
`define FSPS_UNLOCK_KEY      8'ha5
`define FSPS_MODE_ON         8'h01
`define FSPS_MODE_ON_INV     8'hfe
`define FSPS_MODE_OFF        8'h00
`define FSPS_MODE_OFF_INV    8'hff

// status field positions
`define FSPS_ST_SEQ_ERR      0
`define FSPS_ST_VERIFY_ERR   1
`define FSPS_ST_PROT_ERR     2

// interrupt status field positions
`define FSPS_IRQ_DONE        0
`define FSPS_IRQ_ERR         1
`define FSPS_IRQ_W           2

// reset values and fixed figures
`define FSPS_RST_BYTE        8'h00
`define FSPS_RST_PROT        5'h1f
`define FSPS_ERASED_BYTE     8'hff
`define FSPS_OFS_FULL        8'hff
`define FSPS_DONE_LATENCY    4'h2

`endif

// ===== logic/fsps_pkg.sv
package fsps_pkg;
	typedef enum logic [6:0] {
		FSPS_IDLE   = 7'b0000001,
		FSPS_CHECK  = 7'b0000010,
		FSPS_ERASE  = 7'b0000100,
		FSPS_BLANK  = 7'b0001000,
		FSPS_WRITE  = 7'b0010000,
		FSPS_VERIFY = 7'b0100000,
		FSPS_DONE   = 7'b1000000
	} fsps_state_t;

	typedef enum logic [3:0] {
		FSPS_SEQ_IDLE  = 4'b0001,
		FSPS_SEQ_KEYED = 4'b0010,
		FSPS_SEQ_VAL   = 4'b0100,
		FSPS_SEQ_INV   = 4'b1000
	} fsps_seq_t;
endpackage

// ===== logic/fsps_sticky_bit.sv
`timescale 1ns/100ps
// one sticky flag: set wins over clear
module fsps_sticky_bit
	import fsps_pkg::*;
(
	input  wire logic i_sys_clk,
	input  wire logic i_rst_n,
	input  wire logic i_ce,
	input  wire logic i_set,
	input  wire logic i_clr,
	output logic      o_flag
);
	logic flag_reg;
	logic flag_next;

	always_comb begin
		flag_next = flag_reg;
		if (i_clr) begin
			flag_next = 1'b0;
		end
		if (i_set) begin
			flag_next = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flag_reg <= 1'b0;
		end else if (i_ce) begin
			flag_reg <= flag_next;
		end
	end

	assign o_flag = flag_reg;
endmodule

// ===== logic/fsps_unlock_seq.sv
`timescale 1ns/100ps
`include "fsps_defs.svh"
// key, value, inverted value, value: the final write takes effect
module fsps_unlock_seq
	import fsps_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ce,
	input  wire logic       i_key_wr,
	input  wire logic       i_mode_wr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_other_wr,
	output logic            o_mode,
	output logic            o_seq_err
);
	fsps_seq_t  seq_reg;
	fsps_seq_t  seq_next;
	logic [7:0] val_reg;
	logic [7:0] val_next;
	logic       mode_reg;
	logic       mode_next;
	logic       err_pulse;

	always_comb begin
		seq_next  = seq_reg;
		val_next  = val_reg;
		mode_next = mode_reg;
		err_pulse = 1'b0;
		case (seq_reg)
			FSPS_SEQ_IDLE: begin
				if (i_key_wr && i_wdata == `FSPS_UNLOCK_KEY) begin
					seq_next = FSPS_SEQ_KEYED;
				end else if (i_mode_wr) begin
					err_pulse = 1'b1;
				end
			end
			FSPS_SEQ_KEYED: begin
				if (i_mode_wr && (i_wdata == `FSPS_MODE_ON || i_wdata == `FSPS_MODE_OFF)) begin
					val_next = i_wdata;
					seq_next = FSPS_SEQ_VAL;
				end else if (i_mode_wr || i_key_wr || i_other_wr) begin
					err_pulse = 1'b1;
					seq_next  = FSPS_SEQ_IDLE;
				end
			end
			FSPS_SEQ_VAL: begin
				if (i_mode_wr && i_wdata == ~val_reg) begin
					seq_next = FSPS_SEQ_INV;
				end else if (i_mode_wr || i_key_wr || i_other_wr) begin
					err_pulse = 1'b1;
					seq_next  = FSPS_SEQ_IDLE;
				end
			end
			FSPS_SEQ_INV: begin
				if (i_mode_wr && i_wdata == val_reg) begin
					mode_next = (val_reg == `FSPS_MODE_ON);
					seq_next  = FSPS_SEQ_IDLE;
				end else if (i_mode_wr || i_key_wr || i_other_wr) begin
					err_pulse = 1'b1;
					seq_next  = FSPS_SEQ_IDLE;
				end
			end
			default: begin
				seq_next = FSPS_SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			seq_reg  <= FSPS_SEQ_IDLE;
			val_reg  <= `FSPS_RST_BYTE;
			mode_reg <= 1'b0;
		end else if (i_ce) begin
			seq_reg  <= seq_next;
			val_reg  <= val_next;
			mode_reg <= mode_next;
		end
	end

	assign o_mode    = mode_reg;
	assign o_seq_err = err_pulse;
endmodule

// ===== logic/fsps_sequencer.sv
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "fsps_defs.svh"
// Operation
// - code 03 erases the whole block
// - code 04 checks block is blank
// - code 05 programs one byte location
// - byte value comes from write buffer
// - halt starts command, finish releases cpu
// - status bit1 verify error, bit2 protect
// - erase of protected block flags protection
// - zero status means normal completion
// - unlock sequence enables mode; bit0 error
module fsps_sequencer
	import fsps_pkg::*;
#(
	parameter int BLK_W = 5,
	parameter int OFS_W = 8
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ce,
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic [7:0]      o_rdata,
	input  wire logic       i_cpu_halt,
	output logic            o_cpu_release,
	output logic            o_busy,
	output logic            o_mem_en,
	output logic            o_mem_we,
	output logic            o_mem_erase,
	output logic [15:0]     o_mem_addr,
	output logic [7:0]      o_mem_wdata,
	input  wire logic [7:0] i_mem_rdata,
	output logic            o_irq
);
	initial begin
		if (BLK_W < 1 || BLK_W > 8 || OFS_W < 1 || OFS_W > 8) begin
			$error("fsps_sequencer: pointer widths must be 1..8");
		end
	end

	localparam logic [OFS_W-1:0] OFS_LAST = {OFS_W{1'b1}};

	fsps_state_t      st_reg;
	fsps_state_t      st_next;
	logic [7:0]       cmd_reg, cmd_next;
	logic [7:0]       blk_reg, blk_next;
	logic [7:0]       ofs_reg, ofs_next;
	logic [7:0]       blkc_reg, blkc_next;
	logic [7:0]       ofsc_reg, ofsc_next;
	logic [7:0]       wbuf_reg, wbuf_next;
	logic [4:0]       prot_reg, prot_next;
	logic [2:0]       mask_reg, mask_next;
	logic [OFS_W-1:0] cnt_reg, cnt_next;
	logic [3:0]       dly_reg, dly_next;
	logic [7:0]       rdata_reg, rdata_next;
	logic             halt_d_reg;
	logic             verr_set, perr_set, done_set;
	logic             mode_on, seq_err_pulse;
	logic [2:0]       status;
	logic [2:0]       irq_stat;
	logic [2:0]       st_clr, irq_clr, irq_set;
	logic             wr_key, wr_mode, wr_other;
	logic             halt_rise, blk_protected;

	assign wr_key    = i_wr && i_addr == `FSPS_ADDR_UNLOCK;
	assign wr_mode   = i_wr && i_addr == `FSPS_ADDR_MODE;
	assign wr_other  = i_wr && !wr_key && !wr_mode;
	assign halt_rise = i_cpu_halt && !halt_d_reg;
	// protection setting: the lowest 2*(1f - code) blocks stay locked, none at 1f
	assign blk_protected = (prot_reg != `FSPS_RST_PROT) &&
	                       ({3'h0, blk_reg[4:0]} < {2'h0, (`FSPS_RST_PROT - prot_reg), 1'b0});

	fsps_unlock_seq u_unlock (
		.i_sys_clk  (i_sys_clk),
		.i_rst_n    (i_rst_n),
		.i_ce       (i_ce),
		.i_key_wr   (wr_key),
		.i_mode_wr  (wr_mode),
		.i_wdata    (i_wdata),
		.i_other_wr (wr_other),
		.o_mode     (mode_on),
		.o_seq_err  (seq_err_pulse)
	);

	// status is written to zero by software; any write clears all flags except one set in that same cycle
	always_comb begin
		st_clr  = {3{i_wr && i_addr == `FSPS_ADDR_STATUS}};
		irq_clr = (i_wr && i_addr == `FSPS_ADDR_IRQ_STAT) ? i_wdata[2:0] : 3'h0;
		irq_set = {seq_err_pulse, verr_set | perr_set, done_set};
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_flags
			fsps_sticky_bit u_st (
				.i_sys_clk (i_sys_clk),
				.i_rst_n   (i_rst_n),
				.i_ce      (i_ce),
				.i_set     ((g == `FSPS_ST_SEQ_ERR) ? seq_err_pulse :
				            (g == `FSPS_ST_VERIFY_ERR) ? verr_set : perr_set),
				.i_clr     (st_clr[g]),
				.o_flag    (status[g])
			);
			fsps_sticky_bit u_irq (
				.i_sys_clk (i_sys_clk),
				.i_rst_n   (i_rst_n),
				.i_ce      (i_ce),
				.i_set     (irq_set[g]),
				.i_clr     (irq_clr[g]),
				.o_flag    (irq_stat[g])
			);
		end
	endgenerate

	assign o_irq = |(irq_stat & mask_reg);

	// register writes and read data
	always_comb begin
		cmd_next  = cmd_reg;
		blk_next  = blk_reg;
		ofs_next  = ofs_reg;
		blkc_next = blkc_reg;
		ofsc_next = ofsc_reg;
		wbuf_next = wbuf_reg;
		prot_next = prot_reg;
		mask_next = mask_reg;
		rdata_next = `FSPS_RST_BYTE;
		// pointer registers are frozen while a command runs
		if (i_wr && st_reg == FSPS_IDLE) begin
			case (i_addr)
				`FSPS_ADDR_CMD:      cmd_next  = i_wdata;
				`FSPS_ADDR_BLK_PTR:  blk_next  = i_wdata;
				`FSPS_ADDR_OFS_PTR:  ofs_next  = i_wdata;
				`FSPS_ADDR_BLK_CMP:  blkc_next = i_wdata;
				`FSPS_ADDR_OFS_CMP:  ofsc_next = i_wdata;
				`FSPS_ADDR_WBUF:     wbuf_next = i_wdata;
				`FSPS_ADDR_PROT:     prot_next = i_wdata[4:0];
				`FSPS_ADDR_IRQ_MASK: mask_next = i_wdata[2:0];
				default: begin
				end
			endcase
		end
		if (i_rd) begin
			case (i_addr)
				`FSPS_ADDR_CMD:      rdata_next = cmd_reg;
				`FSPS_ADDR_BLK_PTR:  rdata_next = blk_reg;
				`FSPS_ADDR_OFS_PTR:  rdata_next = ofs_reg;
				`FSPS_ADDR_BLK_CMP:  rdata_next = blkc_reg;
				`FSPS_ADDR_OFS_CMP:  rdata_next = ofsc_reg;
				`FSPS_ADDR_WBUF:     rdata_next = wbuf_reg;
				`FSPS_ADDR_STATUS:   rdata_next = {5'h00, status};
				`FSPS_ADDR_MODE:     rdata_next = {7'h00, mode_on};
				`FSPS_ADDR_PROT:     rdata_next = {3'h0, prot_reg};
				`FSPS_ADDR_IRQ_STAT: rdata_next = {5'h00, irq_stat};
				`FSPS_ADDR_IRQ_MASK: rdata_next = {5'h00, mask_reg};
				default:             rdata_next = `FSPS_RST_BYTE;
			endcase
		end
	end

	// command sequencer
	always_comb begin
		st_next  = st_reg;
		cnt_next = cnt_reg;
		dly_next = dly_reg;
		verr_set = 1'b0;
		perr_set = 1'b0;
		done_set = 1'b0;
		case (st_reg)
			FSPS_IDLE: begin
				if (halt_rise) begin
					st_next = FSPS_CHECK;
				end
			end
			FSPS_CHECK: begin
				cnt_next = ofs_reg[OFS_W-1:0];
				dly_next = `FSPS_DONE_LATENCY;
				st_next  = FSPS_DONE;
				if (!mode_on) begin
					verr_set = 1'b1;
				end else begin
					case (cmd_reg)
						`FSPS_CMD_ERASE: begin
							if (blk_protected) begin
								perr_set = 1'b1;
							end else if (blkc_reg != blk_reg || ofs_reg != `FSPS_RST_BYTE ||
							             ofsc_reg != `FSPS_RST_BYTE) begin
								verr_set = 1'b1;
							end else begin
								cnt_next = '0;
								st_next  = FSPS_ERASE;
							end
						end
						`FSPS_CMD_BLANK: begin
							if (blkc_reg != blk_reg || ofs_reg != `FSPS_RST_BYTE ||
							    ofsc_reg[OFS_W-1:0] != OFS_LAST) begin
								verr_set = 1'b1;
							end else begin
								st_next = FSPS_BLANK;
							end
						end
						`FSPS_CMD_WRITE: begin
							if (blk_protected) begin
								perr_set = 1'b1;
							end else begin
								st_next = FSPS_WRITE;
							end
						end
						default: verr_set = 1'b1;
					endcase
				end
			end
			FSPS_ERASE: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == OFS_LAST) begin
					cnt_next = '0;
					st_next  = FSPS_BLANK; // erase is checked by a blank pass
				end
			end
			FSPS_BLANK: begin
				// memory answers one cycle after the address
				if (dly_reg != 4'h0) begin
					dly_next = dly_reg - 1'b1;
				end else begin
					dly_next = 4'h1;
					if (i_mem_rdata != `FSPS_ERASED_BYTE) begin
						verr_set = 1'b1;
						st_next  = FSPS_DONE;
					end else if (cnt_reg == OFS_LAST) begin
						st_next = FSPS_DONE;
					end else begin
						cnt_next = cnt_reg + 1'b1;
					end
				end
			end
			FSPS_WRITE: begin
				st_next  = FSPS_VERIFY;
				dly_next = `FSPS_DONE_LATENCY;
			end
			FSPS_VERIFY: begin
				if (dly_reg != 4'h0) begin
					dly_next = dly_reg - 1'b1;
				end else begin
					verr_set = i_mem_rdata != wbuf_reg;
					st_next  = FSPS_DONE;
				end
			end
			FSPS_DONE: begin
				done_set = 1'b1;
				st_next  = FSPS_IDLE;
			end
			default: st_next = FSPS_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg     <= FSPS_IDLE;
			cmd_reg    <= `FSPS_CMD_NONE;
			blk_reg    <= `FSPS_RST_BYTE;
			ofs_reg    <= `FSPS_RST_BYTE;
			blkc_reg   <= `FSPS_RST_BYTE;
			ofsc_reg   <= `FSPS_RST_BYTE;
			wbuf_reg   <= `FSPS_RST_BYTE;
			prot_reg   <= `FSPS_RST_PROT;
			mask_reg   <= 3'h0;
			cnt_reg    <= '0;
			dly_reg    <= 4'h0;
			rdata_reg  <= `FSPS_RST_BYTE;
			halt_d_reg <= 1'b0;
		end else if (i_ce) begin
			st_reg     <= st_next;
			cmd_reg    <= cmd_next;
			blk_reg    <= blk_next;
			ofs_reg    <= ofs_next;
			blkc_reg   <= blkc_next;
			ofsc_reg   <= ofsc_next;
			wbuf_reg   <= wbuf_next;
			prot_reg   <= prot_next;
			mask_reg   <= mask_next;
			cnt_reg    <= cnt_next;
			dly_reg    <= dly_next;
			rdata_reg  <= rdata_next;
			halt_d_reg <= i_cpu_halt;
		end
	end

	assign o_rdata       = rdata_reg;
	assign o_cpu_release = st_reg == FSPS_DONE;
	assign o_busy        = st_reg != FSPS_IDLE;
	assign o_mem_en      = st_reg == FSPS_ERASE || st_reg == FSPS_BLANK ||
	                       st_reg == FSPS_WRITE || st_reg == FSPS_VERIFY;
	assign o_mem_we      = st_reg == FSPS_WRITE || st_reg == FSPS_ERASE;
	assign o_mem_erase   = st_reg == FSPS_ERASE;
	assign o_mem_addr    = {blk_reg, 8'(cnt_reg)};
	assign o_mem_wdata   = (st_reg == FSPS_ERASE) ? `FSPS_ERASED_BYTE : wbuf_reg;
endmodule

// ===== verification/fsps_seq_assertions.sv
`timescale 1ns/100ps
module fsps_seq_assertions (
	input wire logic        i_sys_clk,
	input wire logic        i_rst_n,
	input wire logic [3:0]  i_addr,
	input wire logic [7:0]  i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [7:0]  o_rdata,
	input wire logic        i_cpu_halt,
	input wire logic        o_cpu_release,
	input wire logic        o_busy,
	input wire logic        o_mem_en,
	input wire logic        o_mem_we,
	input wire logic        o_mem_erase,
	input wire logic [7:0]  o_mem_wdata,
	input wire logic        o_irq
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	AST_REL_PULSE: assert property (o_cpu_release |=> !o_cpu_release)
		else $error("release held past one cycle");
	AST_HALT_BUSY: assert property ($rose(i_cpu_halt) && !o_busy |=> o_busy)
		else $error("halt did not start a command");
	AST_BUSY_END: assert property ($rose(o_busy) |-> ##[1:1000] o_cpu_release)
		else $error("command never released the cpu");
	AST_WE_EN: assert property (o_mem_we |-> o_mem_en)
		else $error("write strobe without enable");
	AST_ERASE_FF: assert property (o_mem_erase |-> o_mem_wdata == 8'hff)
		else $error("erase data not all ones");
	AST_RD_ONLY: assert property (o_rdata != 8'h00 |-> $past(i_rd))
		else $error("read data outside read slot");
	AST_UNMAPPED: assert property (i_rd && i_addr > 4'hb |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_ST_CLEAR: assert property (i_wr && i_addr == 4'h6 && !o_busy ##[1:2]
		i_rd && i_addr == 4'h6 && !o_busy |=> o_rdata[2:0] == 3'h0)
		else $error("status not cleared by write");
	AST_MASK_OFF: assert property (i_wr && i_addr == 4'hb && i_wdata == 8'h00 && !o_busy
		|=> !o_irq)
		else $error("irq high with all masked");
	COV_REL: cover property (o_cpu_release);
	COV_ERASE: cover property (o_mem_erase);
	COV_WRITE: cover property (o_mem_we && !o_mem_erase);
endmodule

bind fsps_sequencer fsps_seq_assertions u_chk (
	.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cpu_halt(i_cpu_halt),
	.o_cpu_release(o_cpu_release), .o_busy(o_busy), .o_mem_en(o_mem_en),
	.o_mem_we(o_mem_we), .o_mem_erase(o_mem_erase), .o_mem_wdata(o_mem_wdata),
	.o_irq(o_irq)
);

// ===== verification/flash_self_program_sequencer_bench.sv
`timescale 1ns/100ps
`include "fsps_defs.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module flash_self_program_sequencer_bench;
	logic        i_sys_clk   = 1'b0;
	logic        i_rst_n     = 1'b0;
	logic        i_ce        = 1'b1;
	logic [3:0]  i_addr      = 4'h0;
	logic [7:0]  i_wdata     = 8'h00;
	logic        i_wr        = 1'b0;
	logic        i_rd        = 1'b0;
	logic        i_cpu_halt  = 1'b0;
	logic [7:0]  i_mem_rdata = 8'h00;
	logic [7:0]  mem_val     = 8'h00;
	logic [7:0]  o_rdata;
	logic        o_cpu_release;
	logic        o_busy;
	logic        o_mem_en;
	logic        o_mem_we;
	logic        o_mem_erase;
	logic [15:0] o_mem_addr;
	logic [7:0]  o_mem_wdata;
	logic        o_irq;
	logic [15:0] we_a;
	logic [7:0]  we_d;
	logic [7:0]  q;
	int          fail_count  = 0;
	int          n_tests     = 0;

	fsps_sequencer u_dut (
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_cpu_halt(i_cpu_halt), .o_cpu_release(o_cpu_release), .o_busy(o_busy),
		.o_mem_en(o_mem_en), .o_mem_we(o_mem_we), .o_mem_erase(o_mem_erase),
		.o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata),
		.o_irq(o_irq)
	);

	initial begin
		forever #10 i_sys_clk = ~i_sys_clk;
	end
	// flash answers one cycle after the address, as the array would
	always @(posedge i_sys_clk) begin
		i_mem_rdata <= mem_val;
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 q = o_rdata;
	endtask

	task automatic run(input logic [7:0] c, b, o, bc, oc, exp);
		int n;
		wr(`FSPS_ADDR_CMD, c);
		wr(`FSPS_ADDR_BLK_PTR, b);
		wr(`FSPS_ADDR_OFS_PTR, o);
		wr(`FSPS_ADDR_BLK_CMP, bc);
		wr(`FSPS_ADDR_OFS_CMP, oc);
		wr(`FSPS_ADDR_STATUS, 8'h00);
		wr(4'hc, 8'hac);
		@(posedge i_sys_clk);
		i_cpu_halt <= 1'b1;
		n = 0;
		while (o_cpu_release !== 1'b1 && n < 1000) begin
			@(posedge i_sys_clk);
			#1 n++;
			if (o_mem_we === 1'b1) begin
				we_a = o_mem_addr;
				we_d = o_mem_wdata;
			end
		end
		`CHK(n < 1000, 1'b1)
		@(posedge i_sys_clk);
		i_cpu_halt <= 1'b0;
		rd(`FSPS_ADDR_STATUS);
		`CHK(q, exp)
	endtask

	task automatic t_reset;
		rd(`FSPS_ADDR_STATUS);
		`CHK(q, 8'h00)
		rd(`FSPS_ADDR_PROT);
		`CHK(q, 8'h1f)
		rd(4'hc);
		`CHK(q, 8'h00)
		`CHK(o_irq, 1'b0)
		`CHK(o_busy, 1'b0)
		run(`FSPS_CMD_ERASE, 8'h07, 8'h00, 8'h07, 8'h00, 8'h02);
		$display("reset and no-mode test done");
	endtask

	task automatic t_unlock;
		wr(`FSPS_ADDR_STATUS, 8'h00);
		wr(`FSPS_ADDR_UNLOCK, `FSPS_UNLOCK_KEY);
		wr(`FSPS_ADDR_BLK_PTR, 8'h07);
		wr(`FSPS_ADDR_MODE, `FSPS_MODE_ON);
		wr(`FSPS_ADDR_MODE, `FSPS_MODE_ON_INV);
		wr(`FSPS_ADDR_MODE, `FSPS_MODE_ON);
		rd(`FSPS_ADDR_STATUS);
		`CHK(q, 8'h01)
		wr(`FSPS_ADDR_STATUS, 8'h00);
		wr(`FSPS_ADDR_UNLOCK, `FSPS_UNLOCK_KEY);
		wr(`FSPS_ADDR_MODE, `FSPS_MODE_ON);
		wr(`FSPS_ADDR_MODE, `FSPS_MODE_ON_INV);
		wr(`FSPS_ADDR_MODE, `FSPS_MODE_ON);
		rd(`FSPS_ADDR_MODE);
		`CHK(q, 8'h01)
		$display("unlock test done");
	endtask

	task automatic t_write;
		mem_val = 8'h10;
		wr(`FSPS_ADDR_WBUF, 8'h10);
		run(`FSPS_CMD_WRITE, 8'h07, 8'h20, 8'h00, 8'h00, 8'h00);
		`CHK(we_a, 16'h0720)
		`CHK(we_d, 8'h10)
		mem_val = 8'h00;
		run(`FSPS_CMD_WRITE, 8'h07, 8'h20, 8'h00, 8'h00, 8'h02);
		mem_val = 8'hff;
		run(`FSPS_CMD_ERASE, 8'h07, 8'h00, 8'h07, 8'h00, 8'h00);
		mem_val = 8'h10;
		run(`FSPS_CMD_WRITE, 8'h07, 8'h20, 8'h00, 8'h00, 8'h00);
		`CHK(we_d, 8'h10)
		$display("write test done");
	endtask

	task automatic t_erase;
		mem_val = 8'hff;
		run(`FSPS_CMD_ERASE, 8'h07, 8'h00, 8'h07, 8'h00, 8'h00);
		`CHK(we_a, 16'h07ff)
		`CHK(we_d, 8'hff)
		run(`FSPS_CMD_ERASE, 8'h07, 8'h00, 8'h06, 8'h00, 8'h02);
		wr(`FSPS_ADDR_PROT, 8'h1e);
		run(`FSPS_CMD_ERASE, 8'h01, 8'h00, 8'h01, 8'h00, 8'h04);
		wr(`FSPS_ADDR_PROT, 8'h1f);
		// first attempt fails its internal blank pass, the retry succeeds
		mem_val = 8'h00;
		run(`FSPS_CMD_ERASE, 8'h07, 8'h00, 8'h07, 8'h00, 8'h02);
		mem_val = 8'hff;
		run(`FSPS_CMD_ERASE, 8'h07, 8'h00, 8'h07, 8'h00, 8'h00);
		$display("erase test done");
	endtask

	task automatic t_blank;
		run(`FSPS_CMD_BLANK, 8'h05, 8'h00, 8'h05, 8'hff, 8'h00);
		run(`FSPS_CMD_BLANK, 8'h05, 8'h00, 8'h05, 8'h00, 8'h02);
		mem_val = 8'h00;
		run(`FSPS_CMD_BLANK, 8'h05, 8'h00, 8'h05, 8'hff, 8'h02);
		run(8'h07, 8'h05, 8'h00, 8'h05, 8'hff, 8'h02);
		wr(`FSPS_ADDR_STATUS, 8'h00);
		rd(`FSPS_ADDR_STATUS);
		`CHK(q, 8'h00)
		$display("blank test done");
	endtask

	task automatic t_irq;
		mem_val = 8'hff;
		wr(`FSPS_ADDR_IRQ_STAT, 8'hff);
		run(`FSPS_CMD_BLANK, 8'h05, 8'h00, 8'h05, 8'hff, 8'h00);
		rd(`FSPS_ADDR_IRQ_STAT);
		`CHK(q, 8'h01)
		`CHK(o_irq, 1'b0)
		wr(`FSPS_ADDR_IRQ_MASK, 8'h01);
		@(posedge i_sys_clk);
		#1 `CHK(o_irq, 1'b1)
		wr(`FSPS_ADDR_IRQ_STAT, 8'h01);
		@(posedge i_sys_clk);
		#1 `CHK(o_irq, 1'b0)
		wr(`FSPS_ADDR_IRQ_MASK, 8'h00);
		$display("irq test done");
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// worst case is a few thousand cycles; far beyond that means a hang
	initial begin
		#400000;
		fail_count++;
		close_out;
	end

	initial begin
		repeat (8) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		t_reset;
		t_unlock;
		t_write;
		t_erase;
		t_blank;
		t_irq;
		close_out;
	end
endmodule
